// ===== hw/adc_ctrl_consts.svh
// Register indices, reset values and counts of the converter control block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL 16'hF060
`define IDX_START_STATUS 16'hF061
`define IDX_RESULT 16'hF062
`define IDX_IRQ_STATUS 16'hF063
`define IDX_IRQ_CLEAR 16'hF064
`define IDX_IRQ_ENABLE 16'hF065
`define IDX_BANDGAP 16'hF066

// Reset values of the control register fields
`define RST_MODE 1'b0
`define RST_OVS 3'h0
`define RST_REF 2'h3
`define RST_GAIN 2'h0

// Reset values of the start/status register fields
`define RST_GO 1'b1
`define RST_AIN 2'h1
`define RST_BYP 1'b1

// Bit positions in the own registers
`define IRQ_DONE_BIT 0
`define BG_EN_BIT 0
`define BG_PIN_BIT 1

// Largest oversampling divide code that is permitted
`define OVS_MAX 3'h5

// Oversampling ticks that make up one conversion
`define CONV_TICKS_DEF 16383

`endif

// ===== hw/adc_ctrl_pkg.sv
// Types shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;

   typedef enum logic [1:0] {REF_PIN_INPUT, REF_EXT_IN, REF_INT_OUT,
      REF_INT_OUT_GEN} ref_role_e;
   typedef enum logic [1:0] {GAIN_X1, GAIN_X2, GAIN_X4,
      GAIN_THIRD} gain_e;
   typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_e;

   // Control register layout
   typedef struct packed {
      logic continuous_select;
      logic [2:0] oversample_div_select;
      ref_role_e bias_source_select;
      gain_e input_gain_select;
   } ctrl_reg_s;

   // Start/status register layout
   typedef struct packed {
      logic conversion_go;
      logic conversion_busy;
      logic [1:0] input_channel_select;
      logic amplifier_bypass;
      logic [2:0] reserved;
   } ss_reg_s;

   // Controls to the analog front end and modulator
   typedef struct packed {
      logic sample_tick;
      logic converting;
      logic input_channel_select_connect;
      logic ain2_connect;
      logic to_amplifier;
      logic to_modulator;
      gain_e gain;
      logic pin_ref_out_en;
      logic ext_ref_to_gen;
      logic int_ref_to_gen;
      logic bandgap_on;
   } afe_ctrl_s;

endpackage
`default_nettype wire

// ===== hw/delta_sigma_adc_control_regs.sv
// Register control of the delta-sigma converter with APB slave
//
// The APB register port is this design's own decision.
`default_nettype none
`include "adc_ctrl_consts.svh"

module delta_sigma_adc_control_regs
   import adc_ctrl_pkg::*;
#(
   parameter int conv_ticks = `CONV_TICKS_DEF
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modulator bitstream and shared pin
   input wire logic mod_bit,
   input wire logic port_b_bit5_pin_in,
   // Front end controls
   output afe_ctrl_s afe,
   // Interrupt
   output logic irq
);

   localparam logic [13:0] last_tick = 14'(conv_ticks - 1);

   // Word address match against a register index
   function automatic logic reg_hit(input logic [31:0] a,
      input logic [15:0] idx);
      return a[31:2] == {14'h0, idx};
   endfunction

   // Divider terminal count for an oversampling code
   function automatic logic [4:0] div_limit(input logic [2:0] code);
      logic [5:0] n;
      n = 6'h01 << code;
      if (code > `OVS_MAX)
         n = 6'h20;
      return 5'(n - 6'h01);
   endfunction

   ctrl_reg_s ctrl;
   ss_reg_s ss_wr;
   logic go, byp, done_flag, irq_en, bandgap_en;
   logic [1:0] ain;
   logic [13:0] result, ones, tick_cnt;
   logic [4:0] div_cnt;
   logic tick, busy, finish, start_req, wr_acc, setup, err_q, mapped;
   logic [31:0] rd_word;
   conv_state_e state;

   // Bus phase decode; the slave never inserts wait states
   assign wr_acc = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;
   assign ss_wr = ss_reg_s'(pwdata[7:0]);
   assign busy = state == ST_CONVERT;

   // Single conversion request only in wait mode
   assign start_req = wr_acc & reg_hit(paddr, `IDX_START_STATUS) &
      ss_wr.conversion_go & ~ctrl.continuous_select;

   // Control register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl <= {`RST_MODE, `RST_OVS, `RST_REF, `RST_GAIN};
      else if (wr_acc && reg_hit(paddr, `IDX_CONTROL))
         ctrl <= ctrl_reg_s'(pwdata[7:0]);
   end

   // Start/status register; reserved bits are not stored
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         go <= `RST_GO;
         ain <= `RST_AIN;
         byp <= `RST_BYP;
      end
      else if (wr_acc && reg_hit(paddr, `IDX_START_STATUS))
      begin
         go <= ss_wr.conversion_go;
         ain <= ss_wr.input_channel_select;
         byp <= ss_wr.amplifier_bypass;
      end
   end

   // Interrupt enable and bandgap enable registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_en <= 1'b0;
         bandgap_en <= 1'b0;
      end
      else
      begin
         if (wr_acc && reg_hit(paddr, `IDX_IRQ_ENABLE))
            irq_en <= pwdata[`IRQ_DONE_BIT];
         if (wr_acc && reg_hit(paddr, `IDX_BANDGAP))
            bandgap_en <= pwdata[`BG_EN_BIT];
      end
   end

   // Oversampling clock divider
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         div_cnt <= 5'h00;
      else if (div_cnt >= div_limit(ctrl.oversample_div_select))
         div_cnt <= 5'h00;
      else
         div_cnt <= div_cnt + 5'h01;
   end
   assign tick = div_cnt >= div_limit(ctrl.oversample_div_select);
   assign finish = busy & tick & (tick_cnt == last_tick);

   // Conversion sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= ST_IDLE;
      else
      begin
         unique case (state)
            ST_IDLE:
               if (start_req || ctrl.continuous_select)
                  state <= ST_CONVERT;
            ST_CONVERT:
               if (finish && !ctrl.continuous_select)
                  state <= ST_IDLE;
         endcase
      end
   end

   // Count modulator ones over one conversion
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tick_cnt <= 14'h0000;
         ones <= 14'h0000;
      end
      else if (!busy || finish)
      begin
         tick_cnt <= 14'h0000;
         ones <= 14'h0000;
      end
      else if (tick)
      begin
         tick_cnt <= tick_cnt + 14'h0001;
         ones <= ones + {13'h0000, mod_bit};
      end
   end

   // Result capture at the end of a conversion
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         result <= 14'h0000;
      else if (finish)
         result <= ones + {13'h0000, mod_bit};
   end

   // Done flag: set wins; only a written 0 clears it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         done_flag <= 1'b0;
      else if (finish)
         done_flag <= 1'b1;
      else if (wr_acc && reg_hit(paddr, `IDX_IRQ_CLEAR) &&
         !pwdata[`IRQ_DONE_BIT])
         done_flag <= 1'b0;
   end
   assign irq = done_flag & irq_en;

   // Read data and address check
   always_comb
   begin
      rd_word = 32'h0000_0000;
      mapped = 1'b1;
      if (reg_hit(paddr, `IDX_CONTROL))
         rd_word[7:0] = ctrl;
      else if (reg_hit(paddr, `IDX_START_STATUS))
         rd_word[7:0] = {go, busy, ain, byp, 3'h0};
      else if (reg_hit(paddr, `IDX_RESULT))
         rd_word[15:0] = {result, 2'h0};
      else if (reg_hit(paddr, `IDX_IRQ_STATUS))
         rd_word[`IRQ_DONE_BIT] = done_flag;
      else if (reg_hit(paddr, `IDX_IRQ_ENABLE))
         rd_word[`IRQ_DONE_BIT] = irq_en;
      else if (reg_hit(paddr, `IDX_BANDGAP))
      begin
         rd_word[`BG_EN_BIT] = bandgap_en;
         rd_word[`BG_PIN_BIT] = port_b_bit5_pin_in &
            (ctrl.bias_source_select == REF_PIN_INPUT);
      end
      else if (!reg_hit(paddr, `IDX_IRQ_CLEAR))
         mapped = 1'b0;
   end

   // Read data and error are captured in the setup cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         err_q <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         err_q <= ~mapped;
      end
   end

   // Front end controls decoded from the registers
   always_comb
   begin
      afe.sample_tick = tick;
      afe.converting = busy;
      afe.input_channel_select_connect = ain == 2'h1;
      afe.ain2_connect = ain == 2'h2;
      afe.to_amplifier = ~byp;
      afe.to_modulator = byp;
      afe.gain = ctrl.input_gain_select;
      afe.pin_ref_out_en = ctrl.bias_source_select[1];
      afe.ext_ref_to_gen = ctrl.bias_source_select == REF_EXT_IN;
      // Internal reference reaches the generator only on code 11
      afe.int_ref_to_gen = ctrl.bias_source_select ==
         REF_INT_OUT_GEN;
      afe.bandgap_on = bandgap_en;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_div_by_8;
      (tick && ctrl.oversample_div_select == 3'h3) |->
         (ctrl.oversample_div_select == 3'h3) [*8] implies
         (##1 !tick [*7] ##1 tick);
   endproperty
   a_div_by_8: assert property (p_div_by_8)
      else $error("divide by 8 spacing wrong");
   property p_ref_int_gen;
      (wr_acc && reg_hit(paddr, `IDX_CONTROL) && pwdata[3:2] == 2'h3)
         |=> (afe.int_ref_to_gen && afe.pin_ref_out_en &&
         !afe.ext_ref_to_gen);
   endproperty
   a_ref_int_gen: assert property (p_ref_int_gen)
      else $error("reference code 11 not applied");
   property p_gain_third;
      (wr_acc && reg_hit(paddr, `IDX_CONTROL) && pwdata[1:0] == 2'h3)
         |=> afe.gain == GAIN_THIRD;
   endproperty
   a_gain_third: assert property (p_gain_third)
      else $error("gain code 11 not applied");
   property p_start;
      (start_req && state == ST_IDLE) |=> afe.converting;
   endproperty
   a_start: assert property (p_start)
      else $error("go write did not start conversion");
   property p_busy_read;
      (setup && !pwrite && reg_hit(paddr, `IDX_START_STATUS)) |=>
         (prdata[6] == $past(busy) && prdata[2:0] == 3'h0);
   endproperty
   a_busy_read: assert property (p_busy_read)
      else $error("start/status read wrong");
   property p_chan2;
      (wr_acc && reg_hit(paddr, `IDX_START_STATUS) &&
         pwdata[5:4] == 2'h2) |=> (afe.ain2_connect &&
         !afe.input_channel_select_connect);
   endproperty
   a_chan2: assert property (p_chan2)
      else $error("channel 2 not routed");
   property p_bypass;
      (wr_acc && reg_hit(paddr, `IDX_START_STATUS) && pwdata[3]) |=>
         (afe.to_modulator && !afe.to_amplifier);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass not applied");
   property p_continuous;
      (finish && ctrl.continuous_select) |=> afe.converting;
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("continuous mode stopped");
   property p_done_set;
      finish |=> (done_flag && result == $past(ones + {13'h0000,
         mod_bit}));
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag or result not set");
   property p_clear_one;
      (done_flag && wr_acc && reg_hit(paddr, `IDX_IRQ_CLEAR) &&
         pwdata[`IRQ_DONE_BIT]) |=> done_flag;
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("writing 1 cleared done flag");
   property p_reset_vals;
      $fell(rst) |-> (go && ain == 2'h1 && byp &&
         ctrl == 8'h0C);
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset values wrong");

endmodule
`default_nettype wire

// ===== test/afe_model.sv
// Behavioural front end and modulator facing the converter control block
`default_nettype none
module afe_model
   import adc_ctrl_pkg::*;
(
   // Clock
   input wire logic clk,
   // Controls from the block and level chosen by the bench
   input wire afe_ctrl_s afe,
   input wire logic level,
   // Bitstream and shared pin towards the block
   output logic mod_bit,
   output logic pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip = 1'b0;
   // Free toggle stands in for a line that carries nothing
   always @(posedge clk)
   begin
      flip <= ~flip;
   end
   // Bitstream carries the input level only during a conversion
   assign mod_bit = afe.converting ? level : flip;
   // Pin is read as an input only while the block does not drive it
   assign pin_in = afe.pin_ref_out_en ? flip : level;
endmodule
`default_nettype wire

// ===== test/tb_delta_sigma_adc_control_regs.sv
// Self-checking bench of the converter control block
`default_nettype none
`include "adc_ctrl_consts.svh"
module tb_delta_sigma_adc_control_regs
   import adc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CTL = 32'(`IDX_CONTROL) << 2;
   localparam logic [31:0] A_SS = 32'(`IDX_START_STATUS) << 2;
   localparam logic [31:0] A_RES = 32'(`IDX_RESULT) << 2;
   localparam logic [31:0] A_IST = 32'(`IDX_IRQ_STATUS) << 2;
   localparam logic [31:0] A_ICL = 32'(`IDX_IRQ_CLEAR) << 2;
   localparam logic [31:0] A_IEN = 32'(`IDX_IRQ_ENABLE) << 2;
   localparam logic [31:0] A_BG = 32'(`IDX_BANDGAP) << 2;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, mod_bit, pin_in, irq;
   logic level = 1'b1;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   afe_ctrl_s afe;
   int error_cnt = 0, checks = 0, n;
   // Clock of 5 ns period
   always #2.5 clk = ~clk;
   delta_sigma_adc_control_regs #(.conv_ticks(8)) u_dut (.clk(clk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mod_bit(mod_bit), .port_b_bit5_pin_in(pin_in),
      .afe(afe), .irq(irq));
   afe_model u_afe (.clk(clk), .afe(afe), .level(level),
      .mod_bit(mod_bit), .pin_in(pin_in));
   // Verdict and end of run
   task automatic end_sim();
      if (error_cnt == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Compare one value
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(logic wr, logic [31:0] a, logic [31:0] wd,
      output logic [31:0] r, output logic err);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
      begin
         error_cnt++;
         end_sim();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(string what, logic [31:0] a, logic [31:0] exp);
      logic e;
      apb(1'b0, a, '0, rd, e);
      chk(what, rd, exp);
   endtask
   // Watched output: 0 sample tick, 1 converting, otherwise irq
   function automatic logic pick(int s);
      return s == 0 ? afe.sample_tick : (s == 1 ? afe.converting : irq);
   endfunction
   // Wait bounded number of cycles for a flag to reach a value
   task automatic wait_for(int s, logic v);
      for (n = 0; n < 200 && pick(s) !== v; n++)
         @(posedge clk);
      if (n == 200)
      begin
         error_cnt++;
         end_sim();
      end
   endtask
   // Reset values of registers and front end controls
   task automatic t_reset();
      rdc("ctl", A_CTL, 32'h0000_000C);
      rdc("ss", A_SS, 32'h0000_0098);
      chk("afe", 32'(afe), 32'h0000_0A4A);
      chk("irq", 32'(irq), 32'h0);
   endtask
   // Decode of gain, reference, channel, bypass and reserved bits
   task automatic t_fields();
      logic e;
      wr(A_BG, 32'h1); // Bandgap first, then internal reference
      for (int c = 0; c < 4; c++)
      begin
         wr(A_CTL, 32'(8'h0C ^ (c << 2)) | 32'(c));
         @(posedge clk);
         chk("gain", 32'(afe.gain), 32'(c));
         chk("ref", {afe.pin_ref_out_en, afe.ext_ref_to_gen,
            afe.int_ref_to_gen}, {c < 2, c == 2, c == 0});
         wr(A_SS, 32'({1'b0, 1'b0, c[1:0], c[0], 3'h7}));
         rdc("ss", A_SS, 32'({4'(c), c[0], 3'h0}));
         chk("chan", {afe.input_channel_select_connect, afe.ain2_connect},
            {c == 1, c == 2});
         chk("byp", {afe.to_modulator, afe.to_amplifier},
            {c[0], ~c[0]});
      end
      rdc("pin", A_BG, 32'h3); // Pin read as input on code 00
      wr(A_CTL, 32'h0000_000C); // Internal reference feeds generator
      rdc("pin", A_BG, 32'h1);
      chk("bg", 32'(afe.bandgap_on), 32'h1);
      apb(1'b0, 32'h0000_0100, '0, rd, e);
      chk("err", 32'(e), 32'h1);
   endtask
   // Tick spacing for every permitted divide code
   task automatic t_div();
      int k;
      for (int c = 0; c < 6; c++)
      begin
         wr(A_CTL, 32'(8'h0C | (c << 4)));
         wait_for(0, 1'b1);
         @(posedge clk);
         for (k = 1; k < 64 && afe.sample_tick !== 1'b1; k++)
            @(posedge clk);
         chk("div", 32'(k), 32'(1 << c));
      end
      wr(A_CTL, 32'h0000_000C);
   endtask
   // Single conversion, result, busy and sticky done flag
   task automatic t_single();
      wr(A_IEN, 32'h1);
      wr(A_SS, 32'h0000_0098);
      rdc("busy", A_SS, 32'h0000_00D8);
      wait_for(1, 1'b0);
      rdc("res", A_RES, 32'h0000_0020);
      rdc("idle", A_SS, 32'h0000_0098);
      chk("irq", 32'(irq), 32'h1);
      wr(A_ICL, 32'h1);
      rdc("done", A_IST, 32'h1);
      wr(A_ICL, 32'h0);
      rdc("done", A_IST, 32'h0);
      chk("irq", 32'(irq), 32'h0);
   endtask
   // Continuous mode repeats without any start write
   task automatic t_cont();
      wr(A_SS, 32'h0000_0018);
      wr(A_CTL, 32'h0000_008C);
      wait_for(2, 1'b1);
      wr(A_ICL, 32'h0);
      @(posedge clk);
      chk("irq", 32'(irq), 32'h0);
      wait_for(2, 1'b1);
      chk("again", 32'(irq), 32'h1);
      wr(A_CTL, 32'h0000_000C);
      wait_for(1, 1'b0);
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_fields();
      t_div();
      t_single();
      t_cont();
      end_sim();
   end
endmodule
`default_nettype wire
